// >>> sld_ctrl.sv
// Supply level detector control, status and interrupt logic
`timescale 1ns/1ps
`default_nettype none
module sld_ctrl #(
    parameter int SETTLE_CYC = sld_pkg::SETTLE_CYC,
    parameter int PULSE_CYC  = sld_pkg::PULSE_CYC
) (
    input  wire logic                       clock,
    input  wire logic                       reset,
    input  wire logic [sld_pkg::ADDR_W-1:0] address,
    input  wire logic [sld_pkg::DATA_W-1:0] write_data,
    input  wire logic                       write_strobe,
    input  wire logic                       read_strobe,
    output logic      [sld_pkg::DATA_W-1:0] read_data,
    input  wire logic                       comparator_below,
    output logic                            detector_enable,
    output logic      [sld_pkg::SEL_W-1:0]  threshold_select,
    output logic                            low_supply_irq,
    output logic      [sld_pkg::DATA_W-1:0] irq_mid_priority_reg
);
    // Width of the assertion run counters
    localparam int RUN_W = sld_pkg::CNT_W;

    logic                      threshold_band_select_r;
    logic                      threshold_band_select_nxt;
    logic [sld_pkg::TRIM_W-1:0] threshold_trim_r;
    logic [sld_pkg::TRIM_W-1:0] threshold_trim_nxt;
    logic                      enable_r;
    logic                      enable_nxt;
    logic                      irq_status_r;
    logic                      irq_status_nxt;
    logic                      irq_mask_r;
    logic                      irq_mask_nxt;
    logic                      below_prev_r;
    logic                      below_prev_nxt;
    logic [sld_pkg::DATA_W-1:0] read_data_r;
    logic [sld_pkg::DATA_W-1:0] read_data_nxt;
    logic                      irq_r;
    logic                      irq_nxt;
    logic [sld_pkg::SEL_W-1:0]  select_r;
    logic [sld_pkg::SEL_W-1:0]  select_nxt;
    logic [sld_pkg::DATA_W-1:0] route_r;
    logic [sld_pkg::DATA_W-1:0] route_nxt;
    logic                      result_valid_flag;
    logic                      below_filtered;
    logic                      below_threshold_flag;
    logic                      rise_event;
    logic                      settle_done;
    logic [RUN_W-1:0]          on_run_r;
    logic [RUN_W-1:0]          on_run_nxt;
    logic [RUN_W-1:0]          below_run_r;
    logic [RUN_W-1:0]          below_run_nxt;
    logic [RUN_W-1:0]          above_run_r;
    logic [RUN_W-1:0]          above_run_nxt;

    // Valid only after settling, cleared as soon as enable drops
    sld_settle_timer #(
        .CNT_W  (sld_pkg::CNT_W),
        .CYCLES (SETTLE_CYC)
    ) u_settle (
        .clock  (clock),
        .reset  (reset),
        .enable (enable_r),
        .done   (settle_done)
    );
    // Timer clears one edge late, so gate it or valid outlives a disable
    assign result_valid_flag = settle_done & enable_r;

    // Short dips are filtered out before they reach the result bit
    sld_pulse_filter #(
        .CNT_W    (sld_pkg::CNT_W),
        .CYCLES   (PULSE_CYC)
    ) u_filter (
        .clock    (clock),
        .reset    (reset),
        .enable   (enable_r),
        .raw      (comparator_below),
        .filtered (below_filtered)
    );

    assign below_threshold_flag = below_filtered & enable_r;
    // Edge counted only once valid, so settling glitches raise nothing
    assign rise_event = below_threshold_flag & ~below_prev_r & result_valid_flag;

    always_comb begin
        threshold_band_select_nxt = threshold_band_select_r;
        threshold_trim_nxt        = threshold_trim_r;
        enable_nxt                = enable_r;
        irq_mask_nxt              = irq_mask_r;
        irq_status_nxt            = irq_status_r;
        read_data_nxt             = sld_pkg::ZERO_BYTE;
        if (write_strobe) begin
            unique case (address)
                sld_pkg::CTRL_ADDR: begin
                    threshold_band_select_nxt = write_data[sld_pkg::BAND_BIT];
                    threshold_trim_nxt = write_data[sld_pkg::TRIM_LSB +: sld_pkg::TRIM_W];
                end
                sld_pkg::STAT_ADDR: begin
                    enable_nxt = write_data[sld_pkg::ENABLE_BIT];
                end
                sld_pkg::IRQ_MASK_ADDR: begin
                    irq_mask_nxt = write_data[sld_pkg::IRQ_LOW_BIT];
                end
                default: begin
                end
            endcase
        end
        if (read_strobe) begin
            unique case (address)
                sld_pkg::CTRL_ADDR: begin
                    read_data_nxt[sld_pkg::BAND_BIT] = threshold_band_select_r;
                    read_data_nxt[sld_pkg::TRIM_LSB +: sld_pkg::TRIM_W] = threshold_trim_r;
                end
                sld_pkg::STAT_ADDR: begin
                    read_data_nxt[sld_pkg::ENABLE_BIT] = enable_r;
                    read_data_nxt[sld_pkg::VALID_BIT]  = result_valid_flag;
                    read_data_nxt[sld_pkg::BELOW_BIT]  = below_threshold_flag;
                end
                sld_pkg::IRQ_STAT_ADDR: begin
                    read_data_nxt[sld_pkg::IRQ_LOW_BIT] = irq_status_r;
                    irq_status_nxt = 1'b0;
                end
                sld_pkg::IRQ_MASK_ADDR: begin
                    read_data_nxt[sld_pkg::IRQ_LOW_BIT] = irq_mask_r;
                end
                default: begin
                end
            endcase
        end
        // Set wins over the read clear
        if (rise_event) begin
            irq_status_nxt = 1'b1;
        end
    end

    always_comb begin
        below_prev_nxt = below_threshold_flag;
        irq_nxt        = irq_status_nxt & irq_mask_nxt;
        select_nxt     = {threshold_band_select_nxt, threshold_trim_nxt};
        route_nxt      = sld_pkg::ZERO_BYTE;
        route_nxt[sld_pkg::IRQ_ROUTE_BIT] = irq_nxt;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            threshold_band_select_r <= 1'b0;
            threshold_trim_r        <= '0;
            enable_r                <= 1'b0;
            irq_status_r            <= 1'b0;
            irq_mask_r              <= 1'b0;
            below_prev_r            <= 1'b0;
            read_data_r             <= sld_pkg::ZERO_BYTE;
            irq_r                   <= 1'b0;
            select_r                <= '0;
            route_r                 <= sld_pkg::ZERO_BYTE;
        end else begin
            threshold_band_select_r <= threshold_band_select_nxt;
            threshold_trim_r        <= threshold_trim_nxt;
            enable_r                <= enable_nxt;
            irq_status_r            <= irq_status_nxt;
            irq_mask_r              <= irq_mask_nxt;
            below_prev_r            <= below_prev_nxt;
            read_data_r             <= read_data_nxt;
            irq_r                   <= irq_nxt;
            select_r                <= select_nxt;
            route_r                 <= route_nxt;
        end
    end

    assign read_data            = read_data_r;
    assign detector_enable      = enable_r;
    assign threshold_select     = select_r;
    assign low_supply_irq       = irq_r;
    assign irq_mid_priority_reg = route_r;

    // Assertion helpers: saturating run lengths, so long waits need no repetition
    always_comb begin
        on_run_nxt    = on_run_r;
        below_run_nxt = below_run_r;
        above_run_nxt = above_run_r;
        if (!enable_r) begin
            on_run_nxt = '0;
        end else if (on_run_r != '1) begin
            on_run_nxt = on_run_r + 1'b1;
        end
        if (!enable_r || !comparator_below) begin
            below_run_nxt = '0;
        end else if (below_run_r != '1) begin
            below_run_nxt = below_run_r + 1'b1;
        end
        if (!enable_r || comparator_below) begin
            above_run_nxt = '0;
        end else if (above_run_r != '1) begin
            above_run_nxt = above_run_r + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            on_run_r    <= '0;
            below_run_r <= '0;
            above_run_r <= '0;
        end else begin
            on_run_r    <= on_run_nxt;
            below_run_r <= below_run_nxt;
            above_run_r <= above_run_nxt;
        end
    end

    // Assertions
    sequence enable_rise_s;
        write_strobe && address == sld_pkg::STAT_ADDR && write_data[sld_pkg::ENABLE_BIT]
            && !enable_r;
    endsequence

    sequence disable_write_s;
        write_strobe && address == sld_pkg::STAT_ADDR && !write_data[sld_pkg::ENABLE_BIT];
    endsequence

    sequence status_read_s;
        read_strobe && address == sld_pkg::IRQ_STAT_ADDR;
    endsequence

    sequence quiet_read_s;
        status_read_s ##0 !rise_event;
    endsequence

    power_follow_a: assert property (@(posedge clock) disable iff (reset)
        !enable_r |-> !detector_enable && !result_valid_flag && !below_threshold_flag)
        else $error("detector active while disabled");
    enable_start_a: assert property (@(posedge clock) disable iff (reset)
        enable_rise_s |=> enable_r && !result_valid_flag)
        else $error("enable write did not start measurement");
    settle_time_a: assert property (@(posedge clock) disable iff (reset)
        $rose(result_valid_flag) |-> $past(enable_r, 2))
        else $error("valid rose without enable");
    select_map_a: assert property (@(posedge clock) disable iff (reset)
        threshold_select == {threshold_band_select_r, threshold_trim_r})
        else $error("threshold select mismatch");
    band_write_a: assert property (@(posedge clock) disable iff (reset)
        write_strobe && address == sld_pkg::CTRL_ADDR |=>
            threshold_select[sld_pkg::BAND_BIT] == $past(write_data[sld_pkg::BAND_BIT]))
        else $error("band select not taken");
    rise_sets_a: assert property (@(posedge clock) disable iff (reset)
        rise_event |=> irq_status_r)
        else $error("rising result lost");
    no_fall_event_a: assert property (@(posedge clock) disable iff (reset)
        $fell(below_threshold_flag) && !irq_status_r |=> !irq_status_r)
        else $error("event on falling result");
    irq_gate_a: assert property (@(posedge clock) disable iff (reset)
        low_supply_irq == ($past(irq_status_nxt) && $past(irq_mask_nxt))
            && irq_mid_priority_reg[sld_pkg::IRQ_ROUTE_BIT] == low_supply_irq)
        else $error("interrupt gating or routing wrong");
    filter_width_a: assert property (@(posedge clock) disable iff (reset)
        enable_r && !comparator_below |=> !$rose(below_filtered))
        else $error("short excursion detected");
    readonly_a: assert property (@(posedge clock) disable iff (reset)
        read_strobe && address == sld_pkg::CTRL_ADDR |=> read_data[7:4] == 4'h0)
        else $error("reserved bits not zero");

    // Long waits are measured by the run counters rather than by repetition
    rise_width_a: assert property (@(posedge clock) disable iff (reset)
        $rose(below_filtered) |-> below_run_r >= RUN_W'(PULSE_CYC))
        else $error("result rose before minimum width");
    fall_width_a: assert property (@(posedge clock) disable iff (reset)
        $fell(below_filtered) && $past(enable_r) |-> above_run_r >= RUN_W'(PULSE_CYC))
        else $error("result fell before minimum width");
    settle_count_a: assert property (@(posedge clock) disable iff (reset)
        $rose(result_valid_flag) |-> on_run_r == RUN_W'(SETTLE_CYC))
        else $error("valid rose at wrong settling time");
    valid_drop_a: assert property (@(posedge clock) disable iff (reset)
        disable_write_s |=> !result_valid_flag && !below_threshold_flag && !detector_enable)
        else $error("disable did not stop measurement");
    enable_hold_a: assert property (@(posedge clock) disable iff (reset)
        !(write_strobe && address == sld_pkg::STAT_ADDR) |=> $stable(detector_enable))
        else $error("enable changed without write");
    select_hold_a: assert property (@(posedge clock) disable iff (reset)
        !(write_strobe && address == sld_pkg::CTRL_ADDR) |=> $stable(threshold_select))
        else $error("threshold changed without write");
    irq_level_a: assert property (@(posedge clock) disable iff (reset)
        low_supply_irq == (irq_status_r && irq_mask_r))
        else $error("interrupt level not status and mask");
    mask_block_a: assert property (@(posedge clock) disable iff (reset)
        !irq_mask_r |-> !low_supply_irq && !irq_mid_priority_reg[sld_pkg::IRQ_ROUTE_BIT])
        else $error("masked interrupt reached output");
    event_valid_a: assert property (@(posedge clock) disable iff (reset)
        $rose(irq_status_r) |-> $past(result_valid_flag) && $past(below_threshold_flag))
        else $error("event outside valid window");
    read_clear_a: assert property (@(posedge clock) disable iff (reset)
        quiet_read_s |=> !irq_status_r)
        else $error("status read did not clear");
endmodule
`default_nettype wire

// >>> sld_pkg.sv
// Constants shared by the supply level detector control block
package sld_pkg;
    // Register byte addresses
    localparam logic [3:0] CTRL_ADDR      = 4'h0;
    localparam logic [3:0] STAT_ADDR      = 4'h4;
    localparam logic [3:0] IRQ_STAT_ADDR  = 4'h8;
    localparam logic [3:0] IRQ_MASK_ADDR  = 4'hC;
    localparam int         ADDR_W         = 4;
    localparam int         DATA_W         = 8;
    // Control register fields
    localparam int         TRIM_LSB       = 0;
    localparam int         TRIM_W         = 3;
    localparam int         BAND_BIT       = 3;
    // Status register fields
    localparam int         ENABLE_BIT     = 0;
    localparam int         VALID_BIT      = 1;
    localparam int         BELOW_BIT      = 2;
    // Interrupt status bit and default routing in the interrupt manager
    localparam int         IRQ_LOW_BIT    = 0;
    localparam int         IRQ_ROUTE_BIT  = 2;
    localparam logic [7:0] ZERO_BYTE      = 8'h00;
    // Timing
    localparam int         CLK_HZ         = 25000000;
    localparam int         SETTLE_US      = 2000;
    localparam int         MIN_PULSE_US   = 875;
    localparam int         SETTLE_CYC     = SETTLE_US * (CLK_HZ / 1000000);
    localparam int         PULSE_CYC      = MIN_PULSE_US * (CLK_HZ / 1000000);
    localparam int         CNT_W          = 16;
    // Threshold step code: 0 is +19 %, 7 is -18 %; band adds a high bit
    localparam int         SEL_W          = 4;
endpackage

// >>> sld_pulse_filter.sv
// Qualifies the comparator result: a change must persist a minimum time
`timescale 1ns/1ps
`default_nettype none
module sld_pulse_filter #(
    parameter int CNT_W  = 16,
    parameter int CYCLES = 21875
) (
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic enable,
    input  wire logic raw,
    output logic      filtered
);
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic             level_r;
    logic             level_nxt;

    always_comb begin
        count_nxt = '0;
        level_nxt = level_r;
        if (!enable) begin
            level_nxt = 1'b0;
        end else if (raw != level_r) begin
            if (count_r == CNT_W'(CYCLES - 1)) begin
                level_nxt = raw;
            end else begin
                count_nxt = count_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            count_r <= '0;
            level_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            level_r <= level_nxt;
        end
    end

    assign filtered = level_r;
endmodule
`default_nettype wire

// >>> sld_settle_timer.sv
// Settling timer that raises valid a fixed time after enable
`timescale 1ns/1ps
`default_nettype none
module sld_settle_timer #(
    parameter int CNT_W  = 16,
    parameter int CYCLES = 50000
) (
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic enable,
    output logic      done
);
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic             done_r;
    logic             done_nxt;

    always_comb begin
        count_nxt = count_r;
        done_nxt  = done_r;
        if (!enable) begin
            count_nxt = '0;
            done_nxt  = 1'b0;
        end else if (!done_r) begin
            if (count_r == CNT_W'(CYCLES - 1)) begin
                done_nxt = 1'b1;
            end else begin
                count_nxt = count_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            count_r <= '0;
            done_r  <= 1'b0;
        end else begin
            count_r <= count_nxt;
            done_r  <= done_nxt;
        end
    end

    assign done = done_r;
endmodule
`default_nettype wire

// >>> sld_supply_model.sv
// Battery supply and level comparator model facing the detector control
`timescale 1ns/1ps
`default_nettype none
module sld_supply_model (
    input  wire logic                      clock,
    input  wire logic                      detector_enable,
    input  wire logic [sld_pkg::SEL_W-1:0] threshold_select,
    input  wire logic [11:0]               supply_mv,
    output var  logic                      comparator_below
);
    // Typical thresholds in mV, index {band, trim}
    localparam logic [11:0] LEVEL_MV [16] = '{
        12'h5FA, 12'h5A0, 12'h550, 12'h50A, 12'h4C4, 12'h488, 12'h456, 12'h424,
        12'hBF4, 12'hB40, 12'hAA0, 12'hA0A, 12'h988, 12'h91A, 12'h8AC, 12'h852};

    initial comparator_below = 1'b0;

    always @(posedge clock) begin
        if (!detector_enable) begin
            // Unpowered comparator gives no stable level, so keep it moving
            comparator_below <= ~comparator_below;
        end else begin
            comparator_below <= supply_mv < LEVEL_MV[threshold_select];
        end
    end
endmodule
`default_nettype wire

// >>> tb_sld_ctrl.sv
// Self-checking testbench for the supply level detector control
`timescale 1ns/1ps
`default_nettype none
module tb_sld_ctrl;
    // Short counts keep the run brief
    localparam int SETTLE = 8;
    localparam int PULSE  = 4;

    logic                       clock        = 1'b0;
    logic                       reset        = 1'b1;
    logic [sld_pkg::ADDR_W-1:0] address      = 4'h0;
    logic [sld_pkg::DATA_W-1:0] write_data   = 8'h00;
    logic                       write_strobe = 1'b0;
    logic                       read_strobe  = 1'b0;
    logic [sld_pkg::DATA_W-1:0] read_data;
    logic                       comparator_below;
    logic                       detector_enable;
    logic [sld_pkg::SEL_W-1:0]  threshold_select;
    logic                       low_supply_irq;
    logic [sld_pkg::DATA_W-1:0] irq_mid_priority_reg;
    logic [11:0]                supply_mv    = 12'h5DC;
    logic [7:0]                 d;
    int                         n;
    int                         n_mismatch   = 0;
    int                         comparisons  = 0;

    always #20 clock = ~clock;

    sld_ctrl #(.SETTLE_CYC(SETTLE), .PULSE_CYC(PULSE)) sld_ctrl_inst (
        .clock(clock), .reset(reset), .address(address), .write_data(write_data),
        .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
        .comparator_below(comparator_below), .detector_enable(detector_enable),
        .threshold_select(threshold_select), .low_supply_irq(low_supply_irq),
        .irq_mid_priority_reg(irq_mid_priority_reg));

    sld_supply_model sld_supply_model_inst (
        .clock(clock), .detector_enable(detector_enable),
        .threshold_select(threshold_select), .supply_mv(supply_mv),
        .comparator_below(comparator_below));

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Tasks start just after an edge and return 1 ns after one
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        address <= a;
        write_data <= v;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1;
        v = read_data;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask

    task automatic wait_valid();
        n = 0;
        d = 8'h00;
        while (d[sld_pkg::VALID_BIT] !== 1'b1 && n < 40) begin
            rd(sld_pkg::STAT_ADDR, d);
            n++;
        end
    endtask

    task automatic done(input string s);
        $display("test %s done", s);
    endtask

    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        #1;
        for (int i = 0; i < 4; i++) begin
            rd(4'(i * 4), d);
            chk("reset value", d, 8'h00);
        end
        done("reset");
        wr(sld_pkg::CTRL_ADDR, 8'hFF);
        rd(sld_pkg::CTRL_ADDR, d);
        chk("ctrl reserved", d, 8'h0F);
        chk("select", {4'h0, threshold_select}, 8'h0F);
        wr(4'h2, 8'hFF);
        rd(4'h2, d);
        chk("unmapped", d, 8'h00);
        done("registers");
        // Sweep every band and trim code, one measurement each
        for (int b = 0; b < 2; b++) begin
            for (int t = 0; t < 8; t++) begin
                supply_mv <= (b != 0) ? 12'hA28 : 12'h514;
                wr(sld_pkg::CTRL_ADDR, 8'(b * 8 + t));
                wr(sld_pkg::STAT_ADDR, 8'hFF);
                chk("enable", {7'h00, detector_enable}, 8'h01);
                wait_valid();
                chk("settle", 8'(n >= SETTLE - 1 && n <= SETTLE + 3), 8'h01);
                chk("result", d, (t < 3) ? 8'h07 : 8'h03);
                wr(sld_pkg::STAT_ADDR, 8'h00);
            end
        end
        done("threshold sweep");
        rd(sld_pkg::STAT_ADDR, d);
        chk("off status", d, 8'h00);
        rd(sld_pkg::IRQ_STAT_ADDR, d);
        cyc(2 * PULSE + 4);
        rd(sld_pkg::IRQ_STAT_ADDR, d);
        chk("off events", d, 8'h00);
        done("disabled");
        wr(sld_pkg::CTRL_ADDR, 8'h03);
        supply_mv <= 12'h5DC;
        wr(sld_pkg::IRQ_MASK_ADDR, 8'h01);
        wr(sld_pkg::STAT_ADDR, 8'h01);
        wait_valid();
        chk("valid above", d, 8'h03);
        supply_mv <= 12'h4B0;
        cyc(PULSE - 2);
        supply_mv <= 12'h5DC;
        cyc(PULSE + 4);
        rd(sld_pkg::IRQ_STAT_ADDR, d);
        chk("short dip", d, 8'h00);
        supply_mv <= 12'h4B0;
        cyc(PULSE + 4);
        chk("irq out", {7'h00, low_supply_irq}, 8'h01);
        chk("irq route", irq_mid_priority_reg, 8'h04);
        rd(sld_pkg::STAT_ADDR, d);
        chk("below", d, 8'h07);
        rd(sld_pkg::IRQ_STAT_ADDR, d);
        chk("rise event", d, 8'h01);
        cyc(1);
        chk("irq cleared", {7'h00, low_supply_irq}, 8'h00);
        supply_mv <= 12'h5DC;
        cyc(PULSE + 4);
        rd(sld_pkg::IRQ_STAT_ADDR, d);
        chk("fall no event", d, 8'h00);
        wr(sld_pkg::IRQ_MASK_ADDR, 8'h00);
        supply_mv <= 12'h4B0;
        cyc(PULSE + 4);
        chk("masked irq", {7'h00, low_supply_irq}, 8'h00);
        rd(sld_pkg::IRQ_STAT_ADDR, d);
        chk("masked event", d, 8'h01);
        done("interrupt");
        end_of_test();
    end

    // Whole sequence needs well under a thousand cycles
    initial begin
        #(40 * 20000);
        n_mismatch++;
        end_of_test();
    end
endmodule
`default_nettype wire
